// file: hw/ucl_loader.sv
/*
 * Power-up and bus-reset configuration loader of a four-channel USB-UART bridge.
 * Captures straps, reads an 8-byte I2C EEPROM, and presents descriptor fields
 * and CDC-ACM UART defaults. Assumes one clock and synchronous inputs.
 */
`timescale 1ns/1ps
module ucl_loader #(
	parameter int QTR_CYC = ucl_pkg::UCL_QTR_CYC
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        bus_reset,
	input  wire logic        suspend,
	input  wire logic        susp_pin_i,
	output logic             susp_pin_o,
	output logic             susp_pin_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	output logic             cfg_ready,
	output logic             eeprom_valid,
	output logic [15:0]      id_vendor,
	output logic [15:0]      id_product,
	output logic [7:0]       bm_attributes,
	output logic [7:0]       b_max_power,
	output logic [7:0]       num_configs,
	output logic [7:0]       if_per_channel,
	output logic [7:0]       ep_per_channel,
	output logic [7:0]       flow_control,
	output logic [7:0]       pin_function,
	output logic [7:0]       pin_direction,
	output logic [7:0]       pin_event_mask,
	output logic             strap_wakeup,
	output logic             strap_self_pwr
);
	import ucl_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef enum {UCL_S_STRAP, UCL_S_START, UCL_S_DEVW, UCL_S_ADDR, UCL_S_RSTART, UCL_S_DEVR,
		UCL_S_READ, UCL_S_STOP, UCL_S_CHECK, UCL_S_DONE} ucl_st_t;

	typedef struct packed {
		ucl_st_t      st;
		logic         issued;
		logic         fail;
		logic [2:0]   idx;
		logic [63:0]  ee;
		logic         pol_high;
		logic         samp_pend;
		logic         strap_wake;
		logic         strap_self;
		logic         ready;
		logic         valid;
		logic [15:0]  vid;
		logic [15:0]  pid;
		logic [7:0]   attr;
		logic [7:0]   maxpwr;
		logic         susp_o;
		logic         susp_oe;
	} ucl_ld_t;

	ucl_ld_t r;
	ucl_ld_t next_r;

	logic        qtick;
	logic        i_busy;
	logic        i_done;
	logic [7:0]  i_rdata;
	logic        i_err;
	logic        cmd_valid;
	ucl_cmd_t    cmd;
	logic [7:0]  wdata;
	logic        i_sda_oe;
	logic        i_scl_oe;

	// ==========================================================
	// I2C engine
	// ==========================================================
	// Quarter-bit enable; a bench may shorten QTR_CYC to keep its runs brief.
	ucl_tick #(.DIV(QTR_CYC)) u_tick (
		.clk  (clk),
		.srst (srst),
		.tick (qtick)
	);

	// Only the last read is nacked, which tells the memory to let go of the data line.
	ucl_i2c u_i2c (
		.clk       (clk),
		.srst      (srst),
		.qtick     (qtick),
		.cmd_valid (cmd_valid),
		.cmd       (cmd),
		.wdata     (wdata),
		.rd_nack   (r.idx == 3'(UCL_EE_BYTES - 1)),
		.busy      (i_busy),
		.done      (i_done),
		.rdata     (i_rdata),
		.ack_err   (i_err),
		.sda_i     (sda_i),
		.sda_oe    (i_sda_oe),
		.scl_oe    (i_scl_oe)
	);

	// Sequencer command for the current state; issued once per step.
	always_comb
	begin
		cmd   = UCL_CMD_START;
		wdata = 8'h00;
		case (r.st)
			UCL_S_START:  cmd = UCL_CMD_START;
			UCL_S_DEVW:
			begin
				cmd   = UCL_CMD_WRITE;
				wdata = UCL_I2C_ADDR_WR;
			end
			UCL_S_ADDR:
			begin
				cmd   = UCL_CMD_WRITE;
				wdata = 8'h00;	// Word address zero: the image is read from its first byte.
			end
			UCL_S_RSTART: cmd = UCL_CMD_START;
			UCL_S_DEVR:
			begin
				cmd   = UCL_CMD_WRITE;
				wdata = UCL_I2C_ADDR_RD;
			end
			UCL_S_READ:   cmd = UCL_CMD_READ;
			UCL_S_STOP:   cmd = UCL_CMD_STOP;
			default:      cmd = UCL_CMD_START;
		endcase
		// Nothing is issued while the engine is busy or the sequencer has no bus step.
		cmd_valid = !r.issued && !i_busy && (r.st != UCL_S_STRAP) && (r.st != UCL_S_CHECK)
			&& (r.st != UCL_S_DONE);
	end

	// ==========================================================
	// Load sequence and descriptor selection
	// ==========================================================
	// A missing EEPROM shows as a nack; the sequence still stops cleanly, then uses defaults.
	always_comb
	begin
		next_r = r;
		if (cmd_valid)
			next_r.issued = 1'b1;
		if (i_done)
			next_r.issued = 1'b0;
		case (r.st)
			// Straps are taken once, while the engine still leaves both lines released.
			UCL_S_STRAP:
			begin
				next_r.strap_wake = ~sda_i;
				next_r.strap_self = scl_i;
				next_r.st         = UCL_S_START;
			end
			UCL_S_START:  if (i_done) next_r.st = UCL_S_DEVW;
			UCL_S_DEVW:
			begin
				if (i_done)
				begin
					next_r.fail = i_err;
					next_r.st   = i_err ? UCL_S_STOP : UCL_S_ADDR;
				end
			end
			UCL_S_ADDR:
			begin
				if (i_done)
				begin
					next_r.fail = i_err;
					next_r.st   = i_err ? UCL_S_STOP : UCL_S_RSTART;
				end
			end
			UCL_S_RSTART: if (i_done) next_r.st = UCL_S_DEVR;
			UCL_S_DEVR:
			begin
				if (i_done)
				begin
					next_r.fail = i_err;
					next_r.st   = i_err ? UCL_S_STOP : UCL_S_READ;
				end
			end
			// Bytes land at their own offset; the last one is nacked and ends the read.
			UCL_S_READ:
			begin
				if (i_done)
				begin
					next_r.ee[r.idx*8 +: 8] = i_rdata;
					next_r.idx              = r.idx + 3'h1;
					if (r.idx == 3'(UCL_EE_BYTES - 1))
						next_r.st = UCL_S_STOP;
				end
			end
			UCL_S_STOP:   if (i_done) next_r.st = UCL_S_CHECK;
			// A nack anywhere or a wrong signature leaves every loaded byte unused.
			UCL_S_CHECK:
			begin
				next_r.valid = !r.fail && (r.ee[UCL_EE_SIG*8 +: 8] == UCL_SIGNATURE);
				next_r.st    = UCL_S_DONE;
			end
			UCL_S_DONE:   next_r.ready = 1'b1;
			default:      next_r.st = UCL_S_STRAP;
		endcase

		// Descriptor fields follow validity; defaults stand otherwise.
		// They are recomputed every cycle, so they settle one cycle after validity
		// and stay put once the sequencer parks in its done state.
		if (r.valid)
		begin
			next_r.vid    = {r.ee[UCL_EE_VID_HI*8 +: 8], r.ee[UCL_EE_VID_LO*8 +: 8]};
			next_r.pid    = {r.ee[UCL_EE_PID_HI*8 +: 8], r.ee[UCL_EE_PID_LO*8 +: 8]};
			next_r.attr   = r.ee[UCL_EE_ATTR*8 +: 8];
			next_r.maxpwr = r.ee[UCL_EE_MAXPWR*8 +: 8];
		end
		else
		begin
			next_r.vid    = UCL_DEF_VID;
			next_r.pid    = UCL_DEF_PID;
			next_r.attr   = '0;
			next_r.attr[UCL_ATTR_RSVD_BIT] = 1'b1;
			next_r.attr[UCL_ATTR_SELF_BIT] = r.strap_self;
			next_r.attr[UCL_ATTR_WAKE_BIT] = r.strap_wake;
			next_r.maxpwr = UCL_DEF_MAXPWR;
		end

		// Polarity is resampled one cycle after a bus reset, with the pin released.
		// Releasing the pin from the cycle after bus reset rises until the last sample avoids reading our own drive back.
		next_r.samp_pend = bus_reset;
		if (r.samp_pend)
			next_r.pol_high = susp_pin_i;
		next_r.susp_oe = !bus_reset && !r.samp_pend;
		next_r.susp_o  = suspend ? r.pol_high : ~r.pol_high;
	end

	// Reset releases the pin so that the polarity strap can be read on the first cycle after.
	// Descriptor defaults stand during reset so that a host never sees zeros.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r           <= '0;
			r.st        <= UCL_S_STRAP;
			r.samp_pend <= 1'b1;
			r.vid       <= UCL_DEF_VID;
			r.pid       <= UCL_DEF_PID;
			r.attr      <= UCL_DEF_ATTR;
			r.maxpwr    <= UCL_DEF_MAXPWR;
		end
		else
			r <= next_r;
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Open-drain: the driven level is always low.
	assign sda_o          = 1'b0;
	assign scl_o          = 1'b0;
	assign sda_oe         = i_sda_oe;
	assign scl_oe         = i_scl_oe;
	assign susp_pin_o     = r.susp_o;
	assign susp_pin_oe    = r.susp_oe;
	assign cfg_ready      = r.ready;
	assign eeprom_valid   = r.valid;
	assign id_vendor      = r.vid;
	assign id_product     = r.pid;
	assign bm_attributes  = r.attr;
	assign b_max_power    = r.maxpwr;
	// The topology and UART defaults are fixed tie-offs, not state.
	assign num_configs    = UCL_NUM_CONFIG;
	assign if_per_channel = UCL_IF_PER_CH;
	assign ep_per_channel = UCL_EP_PER_CH;
	assign flow_control   = UCL_FLOW_DEF;
	assign pin_function   = UCL_PINFN_DEF;
	assign pin_direction  = UCL_PINDIR_DEF;
	assign pin_event_mask = UCL_PINEVT_DEF;
	assign strap_wakeup   = r.strap_wake;
	assign strap_self_pwr = r.strap_self;
endmodule // ucl_loader

// file: hw/ucl_pkg.sv
/*
 * Constants and types shared by the USB-UART configuration loader.
 * Assumes a single 250 MHz clock and a synchronous active-high reset.
 */
package ucl_pkg;

	// ==========================================================
	// Descriptor defaults
	// ==========================================================
	localparam logic [15:0] UCL_DEF_VID        = 16'h1234;	// Arbitrary value.
	localparam logic [15:0] UCL_DEF_PID        = 16'h5678;	// Arbitrary value.
	localparam logic [7:0]  UCL_SIGNATURE      = 8'h5a;	// Arbitrary value.
	localparam logic [7:0]  UCL_DEF_ATTR       = 8'ha0;
	localparam logic [7:0]  UCL_DEF_MAXPWR     = 8'h2f;
	localparam int          UCL_ATTR_RSVD_BIT  = 7;
	localparam int          UCL_ATTR_SELF_BIT  = 6;
	localparam int          UCL_ATTR_WAKE_BIT  = 5;

	// ==========================================================
	// USB topology
	// ==========================================================
	localparam logic [7:0]  UCL_NUM_CONFIG     = 8'h01;
	localparam logic [7:0]  UCL_IF_PER_CH      = 8'h02;
	localparam logic [7:0]  UCL_EP_PER_CH      = 8'h03;

	// ==========================================================
	// CDC-ACM UART defaults
	// ==========================================================
	localparam logic [7:0]  UCL_FLOW_DEF       = 8'h01;
	localparam logic [7:0]  UCL_PINFN_DEF      = 8'h01;
	localparam logic [7:0]  UCL_PINDIR_DEF     = 8'h08;
	localparam logic [7:0]  UCL_PINEVT_DEF     = 8'h30;

	// ==========================================================
	// EEPROM layout and I2C
	// ==========================================================
	localparam logic [7:0]  UCL_I2C_ADDR_WR    = 8'ha0;
	localparam logic [7:0]  UCL_I2C_ADDR_RD    = 8'ha1;
	localparam int          UCL_EE_BYTES       = 8;
	localparam logic [2:0]  UCL_EE_VID_LO      = 3'h0;
	localparam logic [2:0]  UCL_EE_VID_HI      = 3'h1;
	localparam logic [2:0]  UCL_EE_PID_LO      = 3'h2;
	localparam logic [2:0]  UCL_EE_PID_HI      = 3'h3;
	localparam logic [2:0]  UCL_EE_ATTR        = 3'h4;
	localparam logic [2:0]  UCL_EE_MAXPWR      = 3'h5;
	localparam logic [2:0]  UCL_EE_SIG         = 3'h7;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int          UCL_CLK_MHZ        = 250;
	localparam int          UCL_I2C_KHZ        = 100;
	localparam int          UCL_QTR_CYC        = (UCL_CLK_MHZ * 1000) / (UCL_I2C_KHZ * 4);

	// I2C engine commands.
	typedef enum logic [1:0] {UCL_CMD_START, UCL_CMD_STOP, UCL_CMD_WRITE, UCL_CMD_READ} ucl_cmd_t;

endpackage

// file: hw/ucl_tick.sv
/*
 * Divider that produces a one-cycle enable pulse every DIV cycles.
 * Assumes the common clock and synchronous reset.
 */
`timescale 1ns/1ps
module ucl_tick #(
	parameter int DIV = 625
) (
	input  wire logic clk,
	input  wire logic srst,
	output logic      tick
);
	import ucl_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} ucl_tick_t;

	ucl_tick_t r;
	ucl_tick_t next_r;

	// Count down and pulse at wrap.
	always_comb
	begin
		next_r      = r;
		next_r.tick = 1'b0;
		if (r.cnt == 16'h0000)
		begin
			next_r.cnt  = 16'(DIV - 1);
			next_r.tick = 1'b1;
		end
		else
			next_r.cnt = r.cnt - 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign tick = r.tick;
endmodule // ucl_tick

// file: hw/ucl_i2c.sv
/*
 * Byte-level I2C master: start, stop, write with ack check, read with ack/nack.
 * Assumes an external pull-up on both lines and a quarter-bit enable pulse.
 */
`timescale 1ns/1ps
module ucl_i2c (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             qtick,
	input  wire logic             cmd_valid,
	input  ucl_pkg::ucl_cmd_t     cmd,
	input  wire logic [7:0]       wdata,
	input  wire logic             rd_nack,
	output logic                  busy,
	output logic                  done,
	output logic [7:0]            rdata,
	output logic                  ack_err,
	input  wire logic             sda_i,
	output logic                  sda_oe,
	output logic                  scl_oe
);
	import ucl_pkg::*;

	typedef enum {UCL_I_IDLE, UCL_I_RUN} ucl_ist_t;

	typedef struct packed {
		ucl_ist_t     st;
		ucl_cmd_t     cmd;
		logic [1:0]   ph;
		logic [3:0]   bitn;
		logic [8:0]   sh;
		logic         nack;
		logic         done;
		logic         err;
		logic [7:0]   rdata;
		logic         sda_oe;
		logic         scl_oe;
	} ucl_i2c_t;

	ucl_i2c_t r;
	ucl_i2c_t next_r;

	// Four phases per bit; the line is pulled low by enabling the driver.
	always_comb
	begin
		next_r      = r;
		next_r.done = 1'b0;
		case (r.st)
			UCL_I_IDLE:
			begin
				if (cmd_valid)
				begin
					next_r.st   = UCL_I_RUN;
					next_r.cmd  = cmd;
					next_r.ph   = 2'h0;
					next_r.bitn = 4'h0;
					next_r.nack = rd_nack;
					// The shift register holds line levels: a zero ninth bit pulls the line low as an ack.
					next_r.sh   = (cmd == UCL_CMD_WRITE) ? {wdata, 1'b1} : {8'hff, rd_nack};
				end
			end
			UCL_I_RUN:
			begin
				if (qtick)
				begin
					next_r.ph = r.ph + 2'h1;
					case (r.cmd)
						UCL_CMD_START:
						begin
							case (r.ph)
								2'h0:
								begin
									next_r.sda_oe = 1'b0;
									next_r.scl_oe = 1'b0;
								end
								2'h1: next_r.sda_oe = 1'b1;
								2'h2: next_r.scl_oe = 1'b1;
								default:
								begin
									next_r.st   = UCL_I_IDLE;
									next_r.done = 1'b1;
								end
							endcase
						end
						UCL_CMD_STOP:
						begin
							case (r.ph)
								2'h0: next_r.sda_oe = 1'b1;
								2'h1: next_r.scl_oe = 1'b0;
								2'h2: next_r.sda_oe = 1'b0;
								default:
								begin
									next_r.st   = UCL_I_IDLE;
									next_r.done = 1'b1;
								end
							endcase
						end
						default:
						begin
							case (r.ph)
								2'h0: next_r.sda_oe = ~r.sh[8];
								2'h1: next_r.scl_oe = 1'b0;
								2'h2: next_r.sh = {r.sh[7:0], sda_i};	// Sample while clock is high.
								default:
								begin
									next_r.scl_oe = 1'b1;
									next_r.bitn   = r.bitn + 4'h1;
									if (r.bitn == 4'h8)
									begin
										next_r.st     = UCL_I_IDLE;
										next_r.done   = 1'b1;
										next_r.sda_oe = 1'b0;
										next_r.err    = (r.cmd == UCL_CMD_WRITE) && r.sh[0];
										next_r.rdata  = r.sh[8:1];
									end
								end
							endcase
						end
					endcase
				end
			end
			default:
				next_r.st = UCL_I_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			r <= '0;
		else
			r <= next_r;
	end

	assign busy    = (r.st != UCL_I_IDLE);
	assign done    = r.done;
	assign rdata   = r.rdata;
	assign ack_err = r.err;
	assign sda_oe  = r.sda_oe;
	assign scl_oe  = r.scl_oe;
endmodule // ucl_i2c

// file: tb/ucl_loader_assertions.sv
/*
 * Port-level assertions for the configuration loader.
 * Assumes one clock and a synchronous active-high reset; bound from the bench.
 */
`timescale 1ns/1ps
module ucl_loader_assertions (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        bus_reset,
	input wire logic        suspend,
	input wire logic        sda_i,
	input wire logic        scl_i,
	input wire logic        susp_pin_o,
	input wire logic        susp_pin_oe,
	input wire logic        sda_oe,
	input wire logic        scl_oe,
	input wire logic        cfg_ready,
	input wire logic        eeprom_valid,
	input wire logic        strap_wakeup,
	input wire logic        strap_self_pwr,
	input wire logic [15:0] id_vendor,
	input wire logic [15:0] id_product,
	input wire logic [7:0]  bm_attributes,
	input wire logic [7:0]  b_max_power,
	input wire logic [7:0]  num_configs,
	input wire logic [7:0]  if_per_channel,
	input wire logic [7:0]  ep_per_channel,
	input wire logic [7:0]  flow_control,
	input wire logic [7:0]  pin_function,
	input wire logic [7:0]  pin_direction,
	input wire logic [7:0]  pin_event_mask
);
	import ucl_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ==========================================================
	// Triggers
	// ==========================================================
	// Polarity may be resampled near resets, so only quiet suspend changes count.
	sequence s_rel;
		srst ##1 !srst;
	endsequence
	sequence s_susp;
		$changed(suspend) && !bus_reset && !$past(bus_reset) && !$past(bus_reset, 2) && !$past(srst)
			&& !$past(srst, 2);
	endsequence

	// ==========================================================
	// Checks
	// ==========================================================
	topo_fixed_a: assert property (num_configs == 8'h01 && if_per_channel == 8'h02 && ep_per_channel == 8'h03)
		else $error("usb topology wrong");
	flow_default_a: assert property (flow_control == 8'h01 && pin_function == 8'h01)
		else $error("flow or pin function default wrong");
	dir_default_a: assert property (pin_direction == 8'h08)
		else $error("pin direction default wrong");
	evt_default_a: assert property (pin_event_mask == 8'h30)
		else $error("pin event mask default wrong");
	susp_follow_a: assert property (s_susp |=> susp_pin_o != $past(susp_pin_o))
		else $error("indicator did not follow suspend");
	susp_release_a: assert property (bus_reset |=> !susp_pin_oe)
		else $error("indicator driven during bus reset");
	strap_capture_a: assert property (disable iff (1'b0) s_rel |=> ##1
		(strap_wakeup == !$past(sda_i, 2) && strap_self_pwr == $past(scl_i, 2)))
		else $error("straps decoded wrongly");
	attr_format_a: assert property (cfg_ready |-> bm_attributes[7] && bm_attributes[4:0] == 5'h00)
		else $error("attribute reserved bits wrong");
	default_ids_a: assert property (cfg_ready && !eeprom_valid |->
		id_vendor == UCL_DEF_VID && id_product == UCL_DEF_PID && b_max_power == 8'h2f)
		else $error("defaults not kept");
	strap_attr_a: assert property (cfg_ready && !eeprom_valid |->
		bm_attributes == {1'b1, strap_self_pwr, strap_wakeup, 5'h00})
		else $error("attributes do not follow straps");
	ready_hold_a: assert property (cfg_ready |=> cfg_ready && $stable(id_vendor) && $stable(id_product)
		&& $stable(bm_attributes) && $stable(b_max_power))
		else $error("descriptor moved after ready");
	reset_state_a: assert property (disable iff (1'b0) srst |=> !cfg_ready && !eeprom_valid
		&& bm_attributes == 8'ha0 && !sda_oe && !scl_oe)
		else $error("reset state wrong");
	cover property (cfg_ready && eeprom_valid);
endmodule // ucl_loader_assertions

// file: tb/ucl_ee_model.sv
/*
 * Behavioural 8-byte configuration memory on the two-wire pins.
 * Assumes the bench resolves both open-drain lines with pull-ups.
 */
`timescale 1ns/1ps
module ucl_ee_model (
	input  wire logic        present,
	input  wire logic [63:0] contents,
	input  wire logic        scl,
	input  wire logic        sda,
	output logic             sda_oe
);
	logic [7:0] sh;
	logic [2:0] ptr = 3'h0;
	logic [1:0] ph;
	logic       act = 1'b0;
	int         n;
	initial sda_oe = 1'b0;

	// A falling data line under a high clock opens a frame; a rising one closes it.
	always @(negedge sda) if (scl && present) {act, n, ph} = {1'b1, 32'd0, 2'd0};
	always @(posedge sda) if (scl) {act, sda_oe} = 2'b00;

	// Bits are taken on the rising clock; read data rotates through sh, so sh[7] is the live bit.
	always @(posedge scl) if (act)
	begin
		n = n + 1;
		if (n <= 8) sh = {sh[6:0], sda};
		if (n == 9 && ph == 2'd2 && sda) act = 1'b0;
	end

	// Answers change only while the clock is low, to avoid false start or stop.
	always @(negedge scl) if (act)
	begin
		if (n == 9)
		begin
			n = 0;
			if (ph == 2'd2) sh = contents[8*ptr +: 8];
			if (ph == 2'd2) ptr = ptr + 3'h1;
		end
		if (n == 8 && ph == 2'd0)
		begin
			act = (sh[7:1] == 7'h50);
			ph = sh[0] ? 2'd2 : 2'd1;
			sda_oe = act;
		end
		else if (n == 8 && ph == 2'd1)
		begin
			ptr = sh[2:0];
			ph = 2'd3;
			sda_oe = 1'b1;
		end
		else
			sda_oe = (ph == 2'd2 && n < 8) ? !sh[7] : 1'b0;
	end
endmodule // ucl_ee_model

// file: tb/test_usb_uart_config_loader.sv
/*
 * Self-checking bench for the configuration loader with a memory model.
 * Assumes the design's package is compiled first.
 */
`timescale 1ns/1ps
module test_usb_uart_config_loader;
	import ucl_pkg::*;
	logic        clk = 0, srst = 1, bus_reset = 0, suspend = 0;
	logic        sda_pull = 1, scl_pull = 1, susp_pull = 1, present = 0;
	logic [63:0] contents = 64'h0;
	logic        susp_pin_o, susp_pin_oe, sda_o, sda_oe, scl_o, scl_oe, ee_oe;
	logic        cfg_ready, eeprom_valid, strap_wakeup, strap_self_pwr;
	logic [15:0] id_vendor, id_product;
	logic [7:0]  bm_attributes, b_max_power, num_configs, if_per_channel, ep_per_channel;
	logic [7:0]  flow_control, pin_function, pin_direction, pin_event_mask;
	int          num_errors = 0, compares = 0;
	// Open-drain lines fall back to their pull level when nobody drives.
	wire sda_w = (sda_oe | ee_oe) ? 1'b0 : sda_pull;
	wire scl_w = scl_oe ? 1'b0 : scl_pull;
	wire susp_w = susp_pin_oe ? susp_pin_o : susp_pull;

	always #2 clk = ~clk;

	// A short quarter-bit keeps the four loads, two of them full, well inside the cycle budget.
	ucl_loader #(.QTR_CYC(8)) uut (.clk, .srst, .bus_reset, .suspend,
		.susp_pin_i(susp_w), .susp_pin_o, .susp_pin_oe,
		.sda_i(sda_w), .sda_o, .sda_oe, .scl_i(scl_w), .scl_o, .scl_oe, .cfg_ready, .eeprom_valid,
		.id_vendor, .id_product, .bm_attributes, .b_max_power, .num_configs, .if_per_channel,
		.ep_per_channel, .flow_control, .pin_function, .pin_direction, .pin_event_mask,
		.strap_wakeup, .strap_self_pwr);
	ucl_ee_model ee (.present, .contents, .scl(scl_w), .sda(sda_w), .sda_oe(ee_oe));

	// ==========================================================
	// Helpers
	// ==========================================================
	task automatic chk(input logic [31:0] got, exp, input string what);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Straps are set before release; the load is awaited under a bound.
	task automatic restart(input logic sd, sc, pr);
		@(posedge clk);
		srst <= 1;
		{sda_pull, scl_pull, present} <= {sd, sc, pr};
		repeat (10) @(posedge clk);
		chk(bm_attributes, 8'ha0, "attributes in reset");
		srst <= 0;
		repeat (8000)
		begin
			@(posedge clk);
			if (cfg_ready === 1'b1) break;
		end
		#1 chk(cfg_ready, 1, "load finished");
	endtask

	task automatic give_verdict;
		$display("%0d errors in %0d compares", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_valid;
		contents <= {UCL_SIGNATURE, 8'h00, 8'h32, 8'he0, 16'h0b1e, 16'hc0de};
		restart(1, 1, 1);
		chk(eeprom_valid, 1, "signature accepted");
		chk({id_vendor, id_product}, 32'hc0de0b1e, "ids from memory");
		chk(bm_attributes, 8'he0, "attributes from memory");
		chk(b_max_power, 8'h32, "power from memory");
		chk({num_configs, if_per_channel, ep_per_channel}, 24'h010203, "topology");
		chk({flow_control, pin_function}, 16'h0101, "flow defaults");
		chk({pin_direction, pin_event_mask}, 16'h0830, "pin defaults");
		$display("t_valid done");
	endtask

	// No memory: a high data line is refused, a low one reads zeros and a bad signature.
	task automatic t_strap(input logic sd, sc);
		restart(sd, sc, 0);
		chk(eeprom_valid, 0, "memory ignored");
		chk({strap_wakeup, strap_self_pwr}, {!sd, sc}, "strap decode");
		chk({id_vendor, id_product}, {UCL_DEF_VID, UCL_DEF_PID}, "default ids");
		chk(b_max_power, 8'h2f, "default power");
		chk(bm_attributes, {1'b1, sc, !sd, 5'h00}, "strap attributes");
		$display("t_strap %b%b done", sd, sc);
	endtask

	task automatic t_susp(input logic pol);
		@(posedge clk);
		susp_pull <= pol;
		bus_reset <= 1;
		repeat (3) @(posedge clk);
		#1 chk(susp_pin_oe, 0, "pin released in bus reset");
		@(posedge clk);
		bus_reset <= 0;
		repeat (4) @(posedge clk);
		suspend <= 1;
		repeat (2) @(posedge clk);
		#1 chk({susp_pin_oe, susp_w}, {1'b1, pol}, "indicator in suspend");
		@(posedge clk);
		suspend <= 0;
		repeat (2) @(posedge clk);
		#1 chk({susp_pin_oe, susp_w}, {1'b1, !pol}, "indicator awake");
		$display("t_susp %b done", pol);
	endtask

	initial
	begin
		t_valid();
		t_strap(1, 0);
		t_strap(1, 1);
		t_strap(0, 1);
		t_susp(1);
		t_susp(0);
		give_verdict();
	end

	// A full load takes about 3,300 cycles and a refused one about 370; the loads and the suspend tests fit in about a quarter of this span.
	initial
	begin
		#120000;
		num_errors++;
		give_verdict();
	end
endmodule // test_usb_uart_config_loader

bind ucl_loader ucl_loader_assertions chk_i (.clk, .srst, .bus_reset, .suspend, .sda_i, .scl_i,
	.susp_pin_o, .susp_pin_oe, .sda_oe, .scl_oe, .cfg_ready, .eeprom_valid, .strap_wakeup,
	.strap_self_pwr, .id_vendor, .id_product, .bm_attributes, .b_max_power, .num_configs,
	.if_per_channel, .ep_per_channel, .flow_control, .pin_function, .pin_direction, .pin_event_mask);
